// ==== design/psi_pkg.sv ====
// package: constants and types of the power state supervisor
package psi_pkg;
  // ****************************************************
  // states
  // ****************************************************
  typedef enum logic [1:0] {ST_UNPOWERED, ST_SAVE, ST_STANDBY, ST_ACTIVE} psi_state_t;
  // ****************************************************
  // register offsets and fields
  // ****************************************************
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h4;
  localparam logic [3:0] OFS_INT_STAT  = 4'h8;
  localparam logic [3:0] OFS_INT_MASK  = 4'hC;
  localparam int         BIT_KICK      = 0;
  localparam int         BIT_BATTERY_REMOVAL_RESTART_ENABLE  = 1;
  localparam int         BIT_STDBY_REQ = 2;
  localparam int         BIT_WD_EXP    = 2;
  localparam int         BIT_BATRM_FLG = 3;
  localparam logic [7:0] SHUTDOWN_INTS = 8'h07;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ****************************************************
  // timing, counted in slow clock periods
  // ****************************************************
  localparam int SLOW_HZ       = 32768;
  localparam int RST_MS        = 10;
  localparam int RST_TICKS     = (RST_MS * SLOW_HZ + 999) / 1000;
  localparam int WD_S          = 8;
  localparam int WD_TICKS      = WD_S * SLOW_HZ;
  localparam int BATRM_S       = 2;
  localparam int BATRM_TICKS   = BATRM_S * SLOW_HZ;
  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic crit;
    logic backup_ok;
    logic io_on;
    logic wake;
  } psi_supply_t;
endpackage : psi_pkg

// ==== design/psi_supervisor.sv ====
// power state supervisor with interrupt aggregator and AXI4-Lite registers
// Function
// - four states: unpowered, save, standby, active
// - standby to active pulses internal regulator reset
// - host reset low 10 ms, and io off
// - critical battery asserts host reset at once
// - watchdog off after reset, kick enables
// - watchdog expiry: standby and expired flag
// - active to standby disables watchdog
// - short battery removal returns save to active
// - restart enable bit, cleared by reset
// - restart flag held until standby/save
// - only critical battery triggers restart
// - restart needs backup battery above minimum
// - all interrupt sources equal priority
// - capture, mask, OR to open-drain request
// - interrupt registers kept except unpowered (code clears only int_stat there, int_mask is kept)
// - active: request while unmasked pending
// - 8-bit read-clear status, no lost events
// - shutdown interrupts cleared active to standby
// - per-source mask bit blocks request
// - status shows masked pending events too
// - unmask pending: request at slow falling edge
// - slow clock out only active, io on
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
module psi_supervisor #(
  parameter int WD_COUNT    = psi_pkg::WD_TICKS,
  parameter int BATRM_COUNT = psi_pkg::BATRM_TICKS
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  // slow clock and supply monitors (asynchronous)
  input  wire logic        CLK_SLOW,
  input  wire logic        BAT_CRIT,
  input  wire logic        BACKUP_OK,
  input  wire logic        IO_ON,
  input  wire logic        WAKE,
  // events from source modules (same clock)
  input  wire logic [7:0]  EVENTS,
  // AXI4-Lite slave
  input  wire logic [3:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // device outputs
  output logic             HOST_RESET_N,
  output logic             IRQ_N_O,
  output logic             IRQ_N_OE,
  output logic             SLOW_CLK_OUT,
  output logic             REG_RESET,
  output logic [1:0]       STATE
);
  // ****************************************************
  // synchronisers and slow edge detect
  // ****************************************************
  logic [4:0]         sync1;
  logic [4:0]         sync2;
  logic               slow_d;
  psi_pkg::psi_supply_t sup;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sync1  <= 5'h00;
      sync2  <= 5'h00;
      slow_d <= 1'b0;
    end else begin
      sync1  <= {CLK_SLOW, BAT_CRIT, BACKUP_OK, IO_ON, WAKE};
      sync2  <= sync1;
      slow_d <= sync2[4];
    end
  end
  assign sup = psi_pkg::psi_supply_t'(sync2[3:0]);
  logic slow_rise;
  logic slow_fall;
  assign slow_rise = sync2[4] & ~slow_d;
  assign slow_fall = ~sync2[4] & slow_d;
  // ****************************************************
  // registers and bus strobes
  // ****************************************************
  psi_pkg::psi_state_t state;
  psi_pkg::psi_state_t next_state;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_got;
  logic        w_got;
  logic        wr_go;
  logic        rd_go;
  logic        wd_en;
  logic        battery_removal_restart_enable;
  logic        stdby_req;
  logic        wd_exp;
  logic        batrm_flg;
  logic [7:0]  int_stat;
  logic [7:0]  int_mask;
  logic        came_active;
  logic        wd_fire;
  logic        batrm_ok;
  logic        rd_stat;
  logic        rd_int;
  logic        kick;
  logic        to_active;
  logic        leave_active;
  assign wr_go   = aw_got && w_got && !BVALID;
  assign rd_go   = ARVALID && ARREADY;
  assign rd_stat = rd_go && ARADDR == psi_pkg::OFS_STATUS;
  assign rd_int  = rd_go && ARADDR == psi_pkg::OFS_INT_STAT;
  assign kick    = wr_go && aw_addr == psi_pkg::OFS_CTRL && w_strb[0]
                   && w_data[psi_pkg::BIT_KICK];
  assign to_active    = next_state == psi_pkg::ST_ACTIVE && state != psi_pkg::ST_ACTIVE;
  assign leave_active = state == psi_pkg::ST_ACTIVE && next_state != psi_pkg::ST_ACTIVE;
  // ****************************************************
  // AXI4-Lite write channel
  // ****************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= psi_pkg::RESP_OKAY;
    end else begin
      AWREADY <= !aw_got && !AWREADY && AWVALID;
      WREADY  <= !w_got && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_got  <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_got  <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        BVALID <= 1'b1;
        BRESP  <= (aw_addr == psi_pkg::OFS_CTRL || aw_addr == psi_pkg::OFS_INT_MASK)
                  ? psi_pkg::RESP_OKAY : psi_pkg::RESP_SLVERR;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end
  // ****************************************************
  // AXI4-Lite read channel
  // ****************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= psi_pkg::RESP_OKAY;
    end else begin
      ARREADY <= ARVALID && !ARREADY && !RVALID;
      if (rd_go) begin
        RVALID <= 1'b1;
        RRESP  <= psi_pkg::RESP_OKAY;
        unique case (ARADDR)
          psi_pkg::OFS_CTRL:     RDATA <= {29'h0, stdby_req, battery_removal_restart_enable, wd_en};
          psi_pkg::OFS_STATUS:   RDATA <= {28'h0, batrm_flg, wd_exp, state};
          psi_pkg::OFS_INT_STAT: RDATA <= {24'h0, int_stat};
          psi_pkg::OFS_INT_MASK: RDATA <= {24'h0, int_mask};
          default: begin
            RDATA <= 32'h0000_0000;
            RRESP <= psi_pkg::RESP_SLVERR;
          end
        endcase
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end
  // ****************************************************
  // control and interrupt mask registers
  // ****************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      battery_removal_restart_enable  <= 1'b0;
      stdby_req <= 1'b0;
      int_mask  <= psi_pkg::MASK_RESET;
    end else begin
      if (wr_go && aw_addr == psi_pkg::OFS_CTRL && w_strb[0]) begin
        battery_removal_restart_enable  <= w_data[psi_pkg::BIT_BATTERY_REMOVAL_RESTART_ENABLE];
        stdby_req <= w_data[psi_pkg::BIT_STDBY_REQ];
      end else if (leave_active) begin
        stdby_req <= 1'b0;
      end
      if (wr_go && aw_addr == psi_pkg::OFS_INT_MASK && w_strb[0]) begin
        int_mask <= w_data[7:0];
      end
    end
  end
  // ****************************************************
  // slow clock timers
  // ****************************************************
  logic [8:0]  rst_cnt;
  logic [31:0] wd_cnt;
  logic [31:0] rm_cnt;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_cnt <= 9'h000;
      wd_cnt  <= 32'h0000_0000;
      wd_en   <= 1'b0;
      rm_cnt  <= 32'h0000_0000;
    end else begin
      if (to_active) begin
        rst_cnt <= 9'h000;
      end else if (slow_rise && rst_cnt != 9'(psi_pkg::RST_TICKS)) begin
        rst_cnt <= rst_cnt + 9'h001;
      end
      if (leave_active || wd_fire) begin
        wd_en <= 1'b0;
      end else if (kick) begin
        wd_en  <= 1'b1;
        wd_cnt <= 32'h0000_0000;
      end else if (wd_en && slow_rise) begin
        wd_cnt <= wd_cnt + 32'h0000_0001;
      end
      if (state != psi_pkg::ST_SAVE) begin
        rm_cnt <= 32'h0000_0000;
      end else if (slow_rise && rm_cnt != 32'(BATRM_COUNT)) begin
        rm_cnt <= rm_cnt + 32'h0000_0001;
      end
    end
  end
  assign wd_fire  = wd_en && wd_cnt == 32'(WD_COUNT - 1) && slow_rise;
  assign batrm_ok = came_active && battery_removal_restart_enable && sup.backup_ok
                    && rm_cnt != 32'(BATRM_COUNT);
  // ****************************************************
  // state machine
  // ****************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      psi_pkg::ST_UNPOWERED: if (sup.backup_ok || !sup.crit) next_state = psi_pkg::ST_SAVE;
      psi_pkg::ST_SAVE: begin
        if (sup.crit && !sup.backup_ok) next_state = psi_pkg::ST_UNPOWERED;
        else if (!sup.crit) next_state = batrm_ok ? psi_pkg::ST_ACTIVE
                                                  : psi_pkg::ST_STANDBY;
      end
      psi_pkg::ST_STANDBY: begin
        if (sup.crit) next_state = psi_pkg::ST_SAVE;
        else if (sup.wake) next_state = psi_pkg::ST_ACTIVE;
      end
      psi_pkg::ST_ACTIVE: begin
        if (sup.crit) next_state = psi_pkg::ST_SAVE;
        else if (wd_fire || stdby_req) next_state = psi_pkg::ST_STANDBY;
      end
    endcase
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state       <= psi_pkg::ST_UNPOWERED;
      came_active <= 1'b0;
    end else begin
      state <= next_state;
      if (state == psi_pkg::ST_ACTIVE && next_state == psi_pkg::ST_SAVE) begin
        came_active <= 1'b1;
      end else if (next_state != psi_pkg::ST_SAVE) begin
        came_active <= 1'b0;
      end
    end
  end
  // ****************************************************
  // status flags
  // ****************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      wd_exp    <= 1'b0;
      batrm_flg <= 1'b0;
    end else begin
      if (wd_fire) begin
        wd_exp <= 1'b1;
      end else if (rd_stat) begin
        wd_exp <= 1'b0;
      end
      if (state == psi_pkg::ST_SAVE && next_state == psi_pkg::ST_ACTIVE) begin
        batrm_flg <= 1'b1;
      end else if (next_state == psi_pkg::ST_STANDBY || next_state == psi_pkg::ST_SAVE) begin
        batrm_flg <= 1'b0;
      end
    end
  end
  // ****************************************************
  // interrupt aggregator
  // ****************************************************
  logic [7:0] next_int_stat;
  always_comb begin
    next_int_stat = int_stat;
    if (rd_int) begin
      next_int_stat = 8'h00;
    end
    if (leave_active && next_state == psi_pkg::ST_STANDBY) begin
      next_int_stat = next_int_stat & ~psi_pkg::SHUTDOWN_INTS;
    end
    if (state == psi_pkg::ST_UNPOWERED) begin
      next_int_stat = 8'h00;
    end else begin
      next_int_stat = next_int_stat | EVENTS;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      int_stat <= 8'h00;
    end else begin
      int_stat <= next_int_stat;
    end
  end
  logic irq_req;
  assign irq_req = state == psi_pkg::ST_ACTIVE && |(int_stat & ~int_mask);
  // ****************************************************
  // outputs
  // ****************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HOST_RESET_N <= 1'b0;
      IRQ_N_O      <= 1'b0;
      IRQ_N_OE     <= 1'b1;
      SLOW_CLK_OUT <= 1'b0;
      REG_RESET    <= 1'b0;
      STATE        <= 2'h0;
    end else begin
      HOST_RESET_N <= state == psi_pkg::ST_ACTIVE && !to_active && !sup.crit
                      && sup.io_on && rst_cnt == 9'(psi_pkg::RST_TICKS);
      if (slow_fall) begin
        IRQ_N_OE <= !irq_req;
      end
      SLOW_CLK_OUT <= sync2[4] && state == psi_pkg::ST_ACTIVE && sup.io_on;
      REG_RESET    <= state == psi_pkg::ST_STANDBY && next_state == psi_pkg::ST_ACTIVE;
      STATE        <= state;
    end
  end
  // ****************************************************
  // assertions
  // ****************************************************
  sequence s_kicked;
    kick && state == psi_pkg::ST_ACTIVE && !leave_active && !wd_fire;
  endsequence
  sequence s_wd_on;
    wd_en [*2];
  endsequence
  AST_FOUR_STATES: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    STATE == $past(state)) else $error("state output does not follow state");
  AST_REG_RESET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == psi_pkg::ST_STANDBY && next_state == psi_pkg::ST_ACTIVE) |=> REG_RESET)
    else $error("no regulator reset on wake");
  AST_RESET_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (HOST_RESET_N && !$past(HOST_RESET_N)) |-> rst_cnt == 9'(psi_pkg::RST_TICKS) && $past(IO_ON, 3))
    else $error("host reset released early");
  AST_CRIT_RESET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    sup.crit |=> !HOST_RESET_N) else $error("host reset not asserted on critical battery");
  AST_WD_ENABLE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_kicked ##1 !leave_active |-> s_wd_on) else $error("kick did not enable watchdog");
  AST_WD_EXPIRE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (wd_fire && !sup.crit && state == psi_pkg::ST_ACTIVE) |=> state == psi_pkg::ST_STANDBY && wd_exp)
    else $error("expiry did not enter standby");
  AST_WD_DISABLE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    leave_active |=> !wd_en) else $error("watchdog still on after leaving active");
  AST_RESTART_FLAG: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ($past(state) == psi_pkg::ST_SAVE && state == psi_pkg::ST_ACTIVE) |-> batrm_flg)
    else $error("restart flag not set");
  AST_RESTART_BACKUP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == psi_pkg::ST_SAVE && next_state == psi_pkg::ST_ACTIVE) |-> sup.backup_ok && battery_removal_restart_enable)
    else $error("restart without backup or enable");
  AST_READ_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (rd_int && state != psi_pkg::ST_UNPOWERED) |=> int_stat == $past(EVENTS))
    else $error("read-clear lost or kept events");
  AST_IRQ_FALL: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!slow_fall) |=> $stable(IRQ_N_OE)) else $error("request changed off slow falling edge");
  AST_SLOW_GATE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SLOW_CLK_OUT |-> $past(state) == psi_pkg::ST_ACTIVE) else $error("slow clock out of active");
endmodule : psi_supervisor

// ==== verif/psi_host_model.sv ====
// host side model: free running slow oscillator and pulled-up interrupt line
module psi_host_model (
  // slow oscillator
  output logic      clk_slow,
  // open-drain interrupt line
  input  wire logic irq_n_o,
  input  wire logic irq_n_oe,
  output logic      irq_line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial clk_slow = 1'b0;
  always #62.5 clk_slow = ~clk_slow;
  // released line floats to the pull-up level
  assign irq_line = irq_n_oe ? 1'b1 : irq_n_o;
endmodule : psi_host_model

// ==== verif/test_psi_supervisor.sv ====
// testbench: supervisor states, reset output, watchdog and interrupts
module test_psi_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************
  // signals
  // ****************************************************
  logic        CLK_SYS, RST_N, CLK_SLOW, BAT_CRIT, BACKUP_OK, IO_ON, WAKE;
  logic [7:0]  EVENTS;
  logic [3:0]  AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA;
  logic [1:0]  BRESP, RRESP, STATE;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic        HOST_RESET_N, IRQ_N_O, IRQ_N_OE, SLOW_CLK_OUT, REG_RESET, IRQ_LINE;
  logic        seen;
  int          error_cnt, comparisons, cycles;

  psi_supervisor #(.WD_COUNT(4), .BATRM_COUNT(8)) psi_supervisor_inst (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CLK_SLOW(CLK_SLOW), .BAT_CRIT(BAT_CRIT),
    .BACKUP_OK(BACKUP_OK), .IO_ON(IO_ON), .WAKE(WAKE), .EVENTS(EVENTS),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .HOST_RESET_N(HOST_RESET_N), .IRQ_N_O(IRQ_N_O),
    .IRQ_N_OE(IRQ_N_OE), .SLOW_CLK_OUT(SLOW_CLK_OUT), .REG_RESET(REG_RESET),
    .STATE(STATE)
  );
  psi_host_model psi_host_model_inst (
    .clk_slow(CLK_SLOW), .irq_n_o(IRQ_N_O), .irq_n_oe(IRQ_N_OE), .irq_line(IRQ_LINE)
  );

  initial CLK_SYS = 1'b0;
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ****************************************************
  // tasks
  // ****************************************************
  task end_of_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : cyc

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done) begin
      @(posedge CLK_SYS);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        done = 1'b1;
        BREADY <= 1'b0;
        chk({30'h0, BRESP}, {30'h0, er}, "write response");
      end
    end
    chk({30'h0, AWVALID, WVALID}, 32'h0, "write channels released");
    // let an edge pass before the next request
    @(posedge CLK_SYS);
  endtask : wr

  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done) begin
      @(posedge CLK_SYS);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        done = 1'b1;
        RREADY <= 1'b0;
        chk(RDATA, ed, "read data");
        chk({30'h0, RRESP}, {30'h0, er}, "read response");
      end
    end
    chk({31'h0, ARVALID}, 32'h0, "read address released");
    // let an edge pass before the next request
    @(posedge CLK_SYS);
  endtask : rd

  task ev(input logic [7:0] e);
    EVENTS <= e;
    @(posedge CLK_SYS);
    EVENTS <= 8'h00;
  endtask : ev

  task go_active();
    int n;
    n = 0;
    WAKE <= 1'b1;
    repeat (20) begin
      @(posedge CLK_SYS);
      if (REG_RESET === 1'b1) n++;
    end
    WAKE <= 1'b0;
    chk(n, 32'h1, "regulator reset pulses");
    chk({30'h0, STATE}, 32'h3, "active state");
  endtask : go_active

  task slow_seen();
    seen = 1'b0;
    repeat (40) begin
      @(posedge CLK_SYS);
      seen = seen | SLOW_CLK_OUT;
    end
  endtask : slow_seen
  // ****************************************************
  // sequence
  // ****************************************************
  initial begin
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    RST_N = 1'b0;
    BAT_CRIT = 1'b0;
    BACKUP_OK = 1'b1;
    IO_ON = 1'b1;
    WAKE = 1'b0;
    EVENTS = 8'h00;
    AWADDR = 4'h0;
    ARADDR = 4'h0;
    WDATA = 32'h0;
    WSTRB = 4'hF;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    cyc(3);
    chk({28'h0, HOST_RESET_N, IRQ_N_OE, STATE}, 32'h4, "outputs in reset");
    RST_N <= 1'b1;
    cyc(30);
    chk({30'h0, STATE}, 32'h2, "standby after power up");
    go_active();
    cyc(3700);
    chk({31'h0, HOST_RESET_N}, 32'h0, "host reset held");
    cyc(600);
    chk({31'h0, HOST_RESET_N}, 32'h1, "host reset released");
    slow_seen();
    chk({31'h0, seen}, 32'h1, "slow clock runs when active");
    IO_ON <= 1'b0;
    cyc(10);
    chk({31'h0, HOST_RESET_N}, 32'h0, "host reset with io off");
    slow_seen();
    chk({31'h0, seen}, 32'h0, "slow clock gated with io off");
    IO_ON <= 1'b1;
    cyc(10);
    rd(psi_pkg::OFS_CTRL, 32'h0, psi_pkg::RESP_OKAY);
    rd(psi_pkg::OFS_INT_MASK, 32'h0, psi_pkg::RESP_OKAY);
    wr(psi_pkg::OFS_STATUS, 32'h0, psi_pkg::RESP_SLVERR);
    rd(4'h2, 32'h0, psi_pkg::RESP_SLVERR);
    wr(psi_pkg::OFS_INT_MASK, 32'h21, psi_pkg::RESP_OKAY);
    ev(8'h21);
    cyc(30);
    chk({31'h0, IRQ_LINE}, 32'h1, "masked events quiet");
    wr(psi_pkg::OFS_INT_MASK, 32'h0, psi_pkg::RESP_OKAY);
    cyc(20);
    chk({31'h0, IRQ_LINE}, 32'h0, "request after unmask");
    rd(psi_pkg::OFS_INT_STAT, 32'h21, psi_pkg::RESP_OKAY);
    rd(psi_pkg::OFS_INT_STAT, 32'h0, psi_pkg::RESP_OKAY);
    WSTRB <= 4'h0;
    wr(psi_pkg::OFS_CTRL, 32'h1, psi_pkg::RESP_OKAY);
    WSTRB <= 4'hF;
    rd(psi_pkg::OFS_CTRL, 32'h0, psi_pkg::RESP_OKAY);
    ev(8'h21);
    wr(psi_pkg::OFS_CTRL, 32'h1, psi_pkg::RESP_OKAY);
    rd(psi_pkg::OFS_CTRL, 32'h1, psi_pkg::RESP_OKAY);
    cyc(100);
    chk({30'h0, STATE}, 32'h2, "watchdog expiry to standby");
    chk({31'h0, IRQ_LINE}, 32'h1, "no request outside active");
    rd(psi_pkg::OFS_STATUS, 32'h6, psi_pkg::RESP_OKAY);
    rd(psi_pkg::OFS_CTRL, 32'h0, psi_pkg::RESP_OKAY);
    ev(8'h40);
    go_active();
    rd(psi_pkg::OFS_INT_STAT, 32'h60, psi_pkg::RESP_OKAY);
    cyc(4400);
    wr(psi_pkg::OFS_CTRL, 32'h2, psi_pkg::RESP_OKAY);
    BAT_CRIT <= 1'b1;
    cyc(8);
    chk({31'h0, HOST_RESET_N}, 32'h0, "host reset on critical battery");
    cyc(10);
    chk({30'h0, STATE}, 32'h1, "save on critical battery");
    BAT_CRIT <= 1'b0;
    cyc(40);
    chk({30'h0, STATE}, 32'h3, "restart after short removal");
    rd(psi_pkg::OFS_STATUS, 32'hB, psi_pkg::RESP_OKAY);
    wr(psi_pkg::OFS_CTRL, 32'h4, psi_pkg::RESP_OKAY);
    cyc(20);
    chk({30'h0, STATE}, 32'h2, "standby request no restart");
    rd(psi_pkg::OFS_STATUS, 32'h2, psi_pkg::RESP_OKAY);
    end_of_test();
  end
endmodule : test_psi_supervisor
